// ---- hw/bsc_device.sv ----
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "bsc_params.svh"

// Notes on behaviour
// - Clamp request high grounds both gate outputs.
// - Alarm clamp field or alarm trip also clamps.
// - Works from reset without any calibration.
// - Track 0, run 1 starts acquisition calibration.
// - Track, run, periodic all set: recalibrate every 13ms.
// - Periodic clear: one tracking calibration per command.
// - Acquisition runs until settled or 4000 cycles; tracking runs a fixed 1024 cycles.
// - Calibration suspends conversions; busy falls when done.
// - Host waits for busy low before converting.
// - Host calibrates only after the DAC power-up wait.
// - Low four configuration bits pick reference sources.
// - Convert at low and high bias, subtract, offset.
// - Result is 12-bit signed, three fraction bits.
// - Host writes temperature command, then pulses trigger.
// - Temperature order: die, remote one, remote two.
// - Queue results only while monitor bit set.
// - Temperature conversions always use internal reference.
// - Sense circuits powered for the whole scan.
// - Continuous temperature scans keep sense power on.
// - Channel gain is 2, 10 or 25.
// - Queued word is channel tag plus 12-bit result.
module bsc_device #(
    parameter int CAL_PERIOD_CYCLES = `BSC_CAL_PERIOD_NS / `BSC_CLK_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    bsc_link_if.device       lk,
    input  wire logic [1:0]  alarm_trip,
    input  wire logic        adc_done,
    input  wire logic [11:0] adc_code,
    input  wire logic        cal_offset_minimised,
    output logic             gate1_to_analog_ground,
    output logic             gate2_to_analog_ground,
    output logic [3:0]       reference_select,
    output logic             adc_reference_internal,
    output logic [4:0]       amplifier_gain_select1,
    output logic [4:0]       amplifier_gain_select2,
    output logic             cal_run,
    output logic             cal_tracking,
    output logic             adc_suspend,
    output logic             temp_sense_power,
    output logic             adc_start,
    output logic             adc_bias_high,
    output logic [1:0]       adc_channel
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    localparam bsc_pkg::bsc_dev_state_t DEV_RESET = '{
        st:        bsc_pkg::BSC_IDLE,
        hw_cfg:    `BSC_HW_RESET,
        alm_clamp: `BSC_ALARM_RESET,
        conv_cmd:  `BSC_CONV_RESET,
        cal_ctl:   `BSC_CAL_RESET,
        default:   '0
    };

    bsc_pkg::bsc_dev_state_t s;
    bsc_pkg::bsc_dev_state_t next_s;
    logic                    trig_fall;
    logic                    go;
    logic                    cont_temp;
    logic [1:0]              ck_mode;
    logic [11:0]             temp_code;
    logic [2:0]              remaining;

    assign ck_mode   = s.hw_cfg[`BSC_HW_CKMODE_LSB +: 2];
    assign trig_fall = s.trig_q & ~lk.conversion_trigger_input_n;
    assign cont_temp = s.conv_cmd[`BSC_CONV_CONT] & s.conv_cmd[`BSC_CONV_TEMP_EN] & (|s.conv_cmd[2:0]);

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;
        next_s.adc_start = 1'b0;
        next_s.res_valid = 1'b0;
        next_s.trig_q = lk.conversion_trigger_input_n;
        // Once a triggered scan has begun, later channels follow without a new trigger,
        // except in the one-channel-per-trigger mode.
        go = (ck_mode == `BSC_CK_AUTO) | trig_fall | (s.scan_started & (ck_mode != `BSC_CK_TRIG_EACH));
        temp_code = adc_code - s.low_code - `BSC_KELVIN_OFFSET;
        remaining = s.scan_mask;
        remaining[s.chan] = 1'b0;

        case (s.st)
            bsc_pkg::BSC_IDLE: begin
                // Calibration takes the idle slot first, so a scan never overlaps it.
                if (s.cal_req) begin
                    next_s.cal_req = 1'b0;
                    next_s.cal_cnt = '0;
                    next_s.st = bsc_pkg::BSC_CAL;
                end else if ((s.scan_mask != 3'h0) && go) begin
                    next_s.chan = bsc_pkg::bsc_first_chan(s.scan_mask);
                    next_s.scan_started = 1'b1;
                    next_s.adc_start = 1'b1;
                    next_s.st = bsc_pkg::BSC_LOW;
                end else if (s.scan_mask == 3'h0) begin
                    // A scan cancelled while it awaits a trigger must not hold busy up.
                    next_s.scan_started = 1'b0;
                end
            end
            bsc_pkg::BSC_CAL: begin
                next_s.cal_cnt = s.cal_cnt + 12'h1;
                if (s.cal_ctl[`BSC_CAL_TRACK]) begin
                    if (s.cal_cnt == `BSC_CAL_TRK_CYC - 12'h1) begin
                        next_s.st = bsc_pkg::BSC_IDLE;
                    end
                end else if (cal_offset_minimised || (s.cal_cnt == `BSC_CAL_ACQ_MAX - 12'h1)) begin
                    next_s.st = bsc_pkg::BSC_IDLE;
                end
            end
            bsc_pkg::BSC_LOW: begin
                if (adc_done) begin
                    next_s.low_code = adc_code;
                    next_s.adc_start = 1'b1;
                    next_s.st = bsc_pkg::BSC_HIGH;
                end
            end
            bsc_pkg::BSC_HIGH: begin
                if (adc_done) begin
                    if (s.hw_cfg[`BSC_HW_MON_QUEUE]) begin
                        next_s.res_data = {`BSC_TAG_DIE + {2'h0, s.chan}, temp_code};
                    end
                    next_s.res_valid = s.hw_cfg[`BSC_HW_MON_QUEUE];
                    next_s.scan_mask = remaining;
                    if (remaining == 3'h0) begin
                        if (cont_temp) begin
                            next_s.scan_mask = s.conv_cmd[2:0];
                        end else begin
                            next_s.scan_started = 1'b0;
                        end
                    end
                    next_s.st = bsc_pkg::BSC_IDLE;
                end
            end
            default: begin
                next_s.st = bsc_pkg::BSC_IDLE;
            end
        endcase

        // Periodic tracking calibration only counts while all three control bits are set.
        // It follows the state machine so that a request raised as a calibration starts is kept.
        if (&s.cal_ctl) begin
            if (s.period_cnt == 21'(CAL_PERIOD_CYCLES - 1)) begin
                next_s.period_cnt = '0;
                next_s.cal_req = 1'b1;
            end else begin
                next_s.period_cnt = s.period_cnt + 21'h1;
            end
        end else begin
            next_s.period_cnt = '0;
        end

        // Writes come last so that a command landing with a clear is kept.
        if (lk.reg_wr) begin
            case (lk.reg_addr)
                `BSC_REG_HW_CONFIG: begin
                    next_s.hw_cfg = lk.reg_wdata;
                end
                `BSC_REG_ALARM_HW: begin
                    next_s.alm_clamp = lk.reg_wdata[1:0];
                end
                `BSC_REG_CONV_CMD: begin
                    next_s.conv_cmd = lk.reg_wdata[7:0];
                    next_s.scan_mask = lk.reg_wdata[`BSC_CONV_TEMP_EN] ? lk.reg_wdata[2:0] : 3'h0;
                end
                `BSC_REG_CAL_CTL: begin
                    next_s.cal_ctl = lk.reg_wdata[2:0];
                    next_s.period_cnt = '0;
                    if (lk.reg_wdata[`BSC_CAL_RUN]) begin
                        next_s.cal_req = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= DEV_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    // The clamp path is combinational on purpose: protection must not wait for a clock edge.
    assign gate1_to_analog_ground = lk.clamp_request_input | s.alm_clamp[0] | alarm_trip[0];
    assign gate2_to_analog_ground = lk.clamp_request_input | s.alm_clamp[1] | alarm_trip[1];

    assign reference_select = s.hw_cfg[3:0];
    assign adc_reference_internal = (s.st == bsc_pkg::BSC_LOW) | (s.st == bsc_pkg::BSC_HIGH)
                                    | ~s.hw_cfg[`BSC_HW_ADC_REF_EXT];
    assign amplifier_gain_select1 = bsc_pkg::bsc_gain(s.hw_cfg[`BSC_HW_GAIN1_LSB +: 2]);
    assign amplifier_gain_select2 = bsc_pkg::bsc_gain(s.hw_cfg[`BSC_HW_GAIN2_LSB +: 2]);

    assign cal_run      = s.st == bsc_pkg::BSC_CAL;
    assign cal_tracking = s.cal_ctl[`BSC_CAL_TRACK];
    assign adc_suspend  = s.st == bsc_pkg::BSC_CAL;
    assign temp_sense_power = s.scan_started | cont_temp;

    assign adc_start     = s.adc_start;
    assign adc_bias_high = s.st == bsc_pkg::BSC_HIGH;
    assign adc_channel   = s.chan;

    // Continuous scans do not raise busy; a pending calibration already does.
    assign lk.busy = s.cal_req | (s.st == bsc_pkg::BSC_CAL) | (s.scan_started & ~s.conv_cmd[`BSC_CONV_CONT]
                     & ((ck_mode != `BSC_CK_TRIG_EACH) | (s.st != bsc_pkg::BSC_IDLE)));
    assign lk.res_valid = s.res_valid;
    assign lk.res_data  = s.res_data;

endmodule

// ---- hw/bsc_host.sv ----
`timescale 1ns/100ps
`include "bsc_params.svh"

module bsc_host (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    bsc_link_if.host         lk
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    localparam int TRIG_CYC    = (`BSC_TRIG_LOW_NS + `BSC_CLK_NS - 1) / `BSC_CLK_NS;
    localparam int DAC_PUP_CYC = (`BSC_DAC_PUP_NS + `BSC_CLK_NS - 1) / `BSC_CLK_NS;

    bsc_pkg::bsc_host_state_t h;
    bsc_pkg::bsc_host_state_t next_h;
    logic                     access;
    logic                     mapped;
    logic                     held;
    logic                     to_cal;
    logic                     to_conv;

    assign access  = psel & penable;
    assign mapped  = (paddr == `BSC_APB_CTRL) | (paddr == `BSC_APB_CMD) | (paddr == `BSC_APB_TRIG)
                     | (paddr == `BSC_APB_STATUS) | (paddr == `BSC_APB_RESULT);
    assign to_cal  = pwdata[19:16] == `BSC_REG_CAL_CTL;
    assign to_conv = pwdata[19:16] == `BSC_REG_CONV_CMD;
    // Stalling the bus rather than dropping the order keeps software simple: it just waits.
    assign held = pwrite & (((paddr == `BSC_APB_CMD) & ((to_cal & (lk.busy | ~h.pup_done))
                                                      | (to_conv & lk.busy)))
                            | ((paddr == `BSC_APB_TRIG) & (lk.busy | (h.trig_cnt != 2'h0))));

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_h = h;
        next_h.reg_wr = 1'b0;
        if (h.trig_cnt != 2'h0) begin
            next_h.trig_cnt = h.trig_cnt - 2'h1;
        end
        if (!h.pup_done) begin
            next_h.pup_cnt = h.pup_cnt + 8'h1;
            next_h.pup_done = h.pup_cnt == 8'(DAC_PUP_CYC - 1);
        end
        if (psel && !penable) begin
            case (paddr)
                `BSC_APB_CTRL:   next_h.prdata = {31'h0, h.clamp};
                `BSC_APB_STATUS: next_h.prdata = {29'h0, h.pup_done, h.result_new, lk.busy};
                `BSC_APB_RESULT: next_h.prdata = {16'h0, h.result};
                default:         next_h.prdata = 32'h0;
            endcase
        end
        if (access && !held) begin
            if (pwrite) begin
                case (paddr)
                    `BSC_APB_CTRL: begin
                        next_h.clamp = pwdata[0];
                    end
                    `BSC_APB_CMD: begin
                        next_h.reg_wr = 1'b1;
                        next_h.reg_addr = pwdata[19:16];
                        next_h.reg_wdata = pwdata[15:0];
                    end
                    `BSC_APB_TRIG: begin
                        next_h.trig_cnt = 2'(TRIG_CYC);
                    end
                    default: begin
                    end
                endcase
            end else if (paddr == `BSC_APB_RESULT) begin
                next_h.result_new = 1'b0;
            end
        end
        // A result arriving with the read that clears the flag is kept.
        if (lk.res_valid) begin
            next_h.result = lk.res_data;
            next_h.result_new = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            h <= '0;
        end else if (ce) begin
            h <= next_h;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    assign prdata  = h.prdata;
    assign pready  = ~held;
    assign pslverr = access & ~mapped;

    assign lk.reg_wr    = h.reg_wr;
    assign lk.reg_addr  = h.reg_addr;
    assign lk.reg_wdata = h.reg_wdata;
    assign lk.conversion_trigger_input_n = h.trig_cnt == 2'h0;
    assign lk.clamp_request_input = h.clamp;

endmodule

// ---- hw/bsc_link_if.sv ----
`timescale 1ns/100ps

interface bsc_link_if;
    logic        reg_wr;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        conversion_trigger_input_n;
    logic        clamp_request_input;
    logic        busy;
    logic        res_valid;
    logic [15:0] res_data;

    modport device (
        input  reg_wr,
        input  reg_addr,
        input  reg_wdata,
        input  conversion_trigger_input_n,
        input  clamp_request_input,
        output busy,
        output res_valid,
        output res_data
    );

    modport host (
        output reg_wr,
        output reg_addr,
        output reg_wdata,
        output conversion_trigger_input_n,
        output clamp_request_input,
        input  busy,
        input  res_valid,
        input  res_data
    );
endinterface

// ---- hw/bsc_params.svh ----
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// Register indices inside the controller, reached over the link.
`define BSC_REG_HW_CONFIG   4'h0
`define BSC_REG_ALARM_HW    4'h1
`define BSC_REG_CONV_CMD    4'h2
`define BSC_REG_CAL_CTL     4'h3

// Hardware configuration register fields.
`define BSC_HW_ADC_REF_EXT  2
`define BSC_HW_GAIN1_LSB    4
`define BSC_HW_GAIN2_LSB    6
`define BSC_HW_CKMODE_LSB   8
`define BSC_HW_MON_QUEUE    10
`define BSC_HW_RESET        16'h0000
`define BSC_ALARM_RESET     2'h0

// Conversion command register fields.
`define BSC_CONV_TEMP_EN    4
`define BSC_CONV_CONT       7
`define BSC_CONV_RESET      8'h00

// Calibration control register fields.
`define BSC_CAL_TRACK       0
`define BSC_CAL_RUN         1
`define BSC_CAL_PERIODIC    2
`define BSC_CAL_RESET       3'h0

// Trigger modes.
`define BSC_CK_AUTO         2'h0
`define BSC_CK_TRIG_EACH    2'h3

// Gain codes and channel tags.
`define BSC_GAIN_LOW        5'h02
`define BSC_GAIN_MID        5'h0a
`define BSC_GAIN_HIGH       5'h19
`define BSC_TAG_DIE         4'h8
`define BSC_KELVIN_OFFSET   12'h889

// Timing.
`define BSC_CLK_NS          10
`define BSC_TRIG_LOW_NS     20
`define BSC_DAC_PUP_NS      2000
`define BSC_CAL_PERIOD_NS   13000000
`define BSC_CAL_TRK_CYC     12'h400
`define BSC_CAL_ACQ_MAX     12'hfa0

// Host APB register byte offsets.
`define BSC_APB_CTRL        12'h000
`define BSC_APB_CMD         12'h004
`define BSC_APB_TRIG        12'h008
`define BSC_APB_STATUS      12'h00c
`define BSC_APB_RESULT      12'h010

`endif

// ---- hw/bsc_pkg.sv ----
`include "bsc_params.svh"

package bsc_pkg;

    typedef enum logic [1:0] {BSC_IDLE, BSC_CAL, BSC_LOW, BSC_HIGH} bsc_state_t;

    typedef struct packed {
        bsc_state_t  st;
        logic [15:0] hw_cfg;
        logic [1:0]  alm_clamp;
        logic [7:0]  conv_cmd;
        logic [2:0]  cal_ctl;
        logic        cal_req;
        logic [11:0] cal_cnt;
        logic [20:0] period_cnt;
        logic [2:0]  scan_mask;
        logic        scan_started;
        logic [1:0]  chan;
        logic        adc_start;
        logic [11:0] low_code;
        logic        trig_q;
        logic        res_valid;
        logic [15:0] res_data;
    } bsc_dev_state_t;

    typedef struct packed {
        logic        clamp;
        logic        reg_wr;
        logic [3:0]  reg_addr;
        logic [15:0] reg_wdata;
        logic [1:0]  trig_cnt;
        logic [7:0]  pup_cnt;
        logic        pup_done;
        logic [15:0] result;
        logic        result_new;
        logic [31:0] prdata;
    } bsc_host_state_t;

    function automatic logic [4:0] bsc_gain(input logic [1:0] sel);
        case (sel)
            2'h0:    bsc_gain = `BSC_GAIN_LOW;
            2'h1:    bsc_gain = `BSC_GAIN_MID;
            default: bsc_gain = `BSC_GAIN_HIGH;
        endcase
    endfunction

    function automatic logic [1:0] bsc_first_chan(input logic [2:0] mask);
        if (mask[0]) begin
            bsc_first_chan = 2'h0;
        end else if (mask[1]) begin
            bsc_first_chan = 2'h1;
        end else begin
            bsc_first_chan = 2'h2;
        end
    endfunction

endpackage

// ---- tb/bsc_link_chk.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Watches the link and the device pins; one clock domain, so defaults apply.
module bsc_link_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clamp_request_input,
    input wire logic        busy,
    input wire logic        res_valid,
    input wire logic [15:0] res_data,
    input wire logic [1:0]  alarm_trip,
    input wire logic        adc_done,
    input wire logic        cal_offset_minimised,
    input wire logic        gate1_to_analog_ground,
    input wire logic        gate2_to_analog_ground,
    input wire logic        cal_run,
    input wire logic        cal_tracking,
    input wire logic        adc_suspend,
    input wire logic        adc_start,
    input wire logic        adc_bias_high,
    input wire logic        adc_reference_internal,
    input wire logic        temp_sense_power
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [11:0] cal_len;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_len <= 12'h000;
        end else if (cal_run) begin
            cal_len <= cal_len + 12'h001;
        end else begin
            cal_len <= 12'h000;
        end
    end

    sequence s_low_done;
        adc_done && !adc_bias_high;
    endsequence

    sequence s_high_start;
        adc_start && adc_bias_high;
    endsequence

    AST_CLAMP_G1: assert property ((clamp_request_input || alarm_trip[0]) |-> gate1_to_analog_ground)
        else $error("gate one not clamped");
    AST_CLAMP_G2: assert property ((clamp_request_input || alarm_trip[1]) |-> gate2_to_analog_ground)
        else $error("gate two not clamped");
    AST_CAL_BUSY: assert property (cal_run |-> busy && adc_suspend && !adc_start)
        else $error("calibration without busy or suspend");
    AST_TRK_LEN: assert property ($fell(cal_run) && cal_tracking |-> cal_len == 12'h400)
        else $error("tracking calibration length wrong");
    AST_ACQ_END: assert property (cal_run && !cal_tracking && cal_offset_minimised |-> ##[1:2] !cal_run)
        else $error("acquisition calibration did not stop");
    AST_BIAS_SEQ: assert property (s_low_done |=> s_high_start)
        else $error("high bias conversion did not follow");
    AST_RES_AFTER_HIGH: assert property (res_valid |-> $past(adc_done) && $past(adc_bias_high))
        else $error("result without high bias conversion");
    AST_RES_TAG: assert property (res_valid |-> res_data[15:12] inside {4'h8, 4'h9, 4'ha})
        else $error("bad channel tag");
    AST_RES_HOLD: assert property (!res_valid |-> $stable(res_data))
        else $error("result word changed without valid");
    AST_SENSE_PWR: assert property (adc_start |-> temp_sense_power)
        else $error("sense power off during conversion");
    AST_TEMP_REF: assert property (adc_start |-> adc_reference_internal)
        else $error("temperature conversion on external reference");
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "bsc_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    logic        ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, err, adc_done = 1'b0, cal_offset_minimised = 1'b0;
    logic        gate1_to_analog_ground, gate2_to_analog_ground, adc_reference_internal, cal_run, cal_tracking;
    logic        adc_suspend, temp_sense_power, adc_start, adc_bias_high;
    logic [1:0]  alarm_trip = 2'h0, adc_channel;
    logic [3:0]  reference_select;
    logic [4:0]  amplifier_gain_select1, amplifier_gain_select2;
    logic [11:0] paddr = 12'h000, adc_code = 12'h000, low_code = 12'h000;
    logic [11:0] tval [3];
    logic [15:0] got [$];
    logic [15:0] cfg;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          adc_wait = 0, fail_count = 0, tests_run = 0, r;

    bsc_link_if lk ();

    // The period must exceed a tracking run, or busy never falls and cal writes stall for good.
    bsc_device #(.CAL_PERIOD_CYCLES(1500)) bsc_device_inst (
        .ref_clk, .rst, .ce, .lk(lk), .alarm_trip, .adc_done, .adc_code, .cal_offset_minimised,
        .gate1_to_analog_ground, .gate2_to_analog_ground, .reference_select, .adc_reference_internal,
        .amplifier_gain_select1, .amplifier_gain_select2, .cal_run, .cal_tracking, .adc_suspend,
        .temp_sense_power, .adc_start, .adc_bias_high, .adc_channel);

    bsc_host bsc_host_inst (
        .ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lk(lk));

    bsc_link_chk bsc_link_chk_inst (
        .ref_clk, .rst, .clamp_request_input(lk.clamp_request_input), .busy(lk.busy),
        .res_valid(lk.res_valid), .res_data(lk.res_data), .alarm_trip, .adc_done, .cal_offset_minimised,
        .gate1_to_analog_ground, .gate2_to_analog_ground, .cal_run, .cal_tracking, .adc_suspend, .adc_start,
        .adc_bias_high, .adc_reference_internal, .temp_sense_power);

    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Converter stand-in: high-bias code is low code plus reading plus Kelvin offset.
    always @(posedge ref_clk) begin
        adc_done <= 1'b0;
        if (adc_start === 1'b1) begin
            adc_wait <= 2 + int'($urandom % 4);
        end else if (adc_wait == 1) begin
            adc_wait <= 0;
            adc_done <= 1'b1;
            adc_code <= adc_bias_high ? low_code + tval[adc_channel] + `BSC_KELVIN_OFFSET : low_code;
        end else if (adc_wait > 1) begin
            adc_wait <= adc_wait - 1;
        end
        if (lk.res_valid === 1'b1) begin
            got.push_back(lk.res_data);
        end
    end

    function automatic logic [4:0] gexp(input logic [1:0] s);
        return (s == 2'h0) ? 5'h02 : (s == 2'h1) ? 5'h0a : 5'h19;
    endfunction

    task automatic report_and_stop();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Stalls may be long; only the watchdog bounds the wait.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [3:0] idx, input logic [15:0] v);
        apb(1'b1, `BSC_APB_CMD, {12'h000, idx, v});
        repeat (3) @(posedge ref_clk);
    endtask

    // The last edge lets the stand-in queue a result that arrives as busy falls.
    task automatic wait_idle();
        repeat (8) @(posedge ref_clk);
        while (lk.busy !== 1'b0) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask

    task automatic count_cals(input int cyc, output int n);
        logic p;
        n = 0;
        p = cal_run;
        repeat (cyc) begin
            @(posedge ref_clk);
            n += (cal_run === 1'b1 && p !== 1'b1) ? 1 : 0;
            p = cal_run;
        end
    endtask

    task automatic run_scan(input logic [7:0] v, input logic [2:0] m, input logic mon, input int nt);
        int j;
        j = 0;
        for (int c = 0; c < 3; c++) begin
            tval[c] = 12'($urandom);
        end
        if (nt == 0 && m == 3'b111) begin
            tval[0] = 12'hec0;
        end
        got.delete();
        cmd(4'h2, {8'h00, v});
        for (int t = 0; t < nt; t++) begin
            apb(1'b1, `BSC_APB_TRIG, 32'h0);
        end
        wait_idle();
        for (int c = 0; c < 3; c++) begin
            if (m[c] && mon && j < got.size()) begin
                `CHK(got[j], {4'h8 + 4'(c), tval[c]})
            end
            j += (m[c] && mon) ? 1 : 0;
        end
        `CHK(got.size(), j)
        $display("scan %h done", v);
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h82becf4c));
        low_code = 12'($urandom);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK({lk.busy, gate1_to_analog_ground, amplifier_gain_select1}, 7'h02)
        apb(1'b1, `BSC_APB_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
        `CHK({gate2_to_analog_ground, gate1_to_analog_ground}, 2'h3)
        apb(1'b1, `BSC_APB_CTRL, 32'h0);
        repeat (3) @(posedge ref_clk);
        `CHK({gate2_to_analog_ground, gate1_to_analog_ground}, 2'h0)
        for (int v = 0; v < 4; v++) begin
            cmd(4'h1, 16'(v));
            `CHK({gate2_to_analog_ground, gate1_to_analog_ground}, 2'(v))
        end
        cmd(4'h1, 16'h0000);
        alarm_trip <= 2'h2;
        repeat (2) @(posedge ref_clk);
        `CHK({gate2_to_analog_ground, gate1_to_analog_ground}, 2'h2)
        alarm_trip <= 2'h0;
        $display("clamp done");
        for (int i = 0; i < 4; i++) begin
            cfg = {8'h00, 2'(i), 2'(3 - i), 4'($urandom)};
            cmd(4'h0, cfg);
            `CHK({reference_select, adc_reference_internal}, {cfg[3:0], ~cfg[2]})
            `CHK({amplifier_gain_select2, amplifier_gain_select1}, {gexp(cfg[7:6]), gexp(cfg[5:4])})
        end
        cmd(4'h0, 16'h0400);
        $display("config done");
        cmd(4'h3, 16'h0002);
        `CHK({lk.busy, cal_tracking}, 2'h2)
        repeat (20) @(posedge ref_clk);
        cal_offset_minimised <= 1'b1;
        wait_idle();
        cal_offset_minimised <= 1'b0;
        `CHK(cal_run, 1'b0)
        cmd(4'h3, 16'h0003);
        `CHK(cal_tracking, 1'b1)
        wait_idle();
        count_cals(300, r);
        `CHK(r, 0)
        cmd(4'h3, 16'h0007);
        count_cals(4000, r);
        `CHK(r >= 2, 1'b1)
        cmd(4'h3, 16'h0001);
        wait_idle();
        count_cals(300, r);
        `CHK(r, 0)
        $display("calibration done");
        run_scan(8'h17, 3'b111, 1'b1, 0);
        apb(1'b0, `BSC_APB_RESULT, 32'h0);
        `CHK(rd[15:0], {4'ha, tval[2]})
        run_scan(8'h13, 3'b011, 1'b1, 0);
        cmd(4'h0, 16'h0500);
        run_scan(8'h13, 3'b011, 1'b1, 1);
        cmd(4'h0, 16'h0700);
        run_scan(8'h17, 3'b111, 1'b1, 3);
        cmd(4'h0, 16'h0000);
        run_scan(8'h13, 3'b011, 1'b0, 0);
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        cmd(4'h2, 16'h0091);
        repeat (200) begin
            @(posedge ref_clk);
            `CHK(temp_sense_power, 1'b1)
        end
        cmd(4'h2, 16'h0000);
        wait_idle();
        repeat (50) @(posedge ref_clk);
        `CHK(temp_sense_power, 1'b0)
        $display("continuous done");
        report_and_stop();
    end
endmodule
